//--- design/pcg_ctrl.v
// Control logic of the system clock generator
`timescale 1ns/100ps
`default_nettype none
`include "pcg_defs.vh"

module pcg_ctrl (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        cpu_src_i,
  input  wire        pci_src_i,
  input  wire        ref_src_i,
  input  wire        usb_src_i,
  input  wire        c24_src_i,
  input  wire        buffer_in_i,
  input  wire        power_down_n_i,
  input  wire [4:0]  tristate_i,
  input  wire        serial_clock_line_i,
  input  wire        serial_data_line_i,
  output reg         serial_data_line_o,
  output reg         serial_data_line_oe_o,
  input  wire        pci_clock_first_i,
  output reg         pci_clock_first_o,
  output reg         pci_clock_first_oe_o,
  input  wire        pci_clock_one_i,
  output reg         pci_clock_one_o,
  output reg         pci_clock_one_oe_o,
  input  wire        ref_clock_second_i,
  output reg         ref_clock_second_o,
  output reg         ref_clock_second_oe_o,
  input  wire        low_rate_fixed_clock_i,
  output reg         low_rate_fixed_clock_o,
  output reg         low_rate_fixed_clock_oe_o,
  input  wire        usb48_clock_i,
  output reg         usb48_clock_o,
  output reg         usb48_clock_oe_o,
  input  wire        ref_clock_strong_i,
  output reg         ref_clock_strong_o,
  output reg         ref_clock_strong_oe_o,
  output reg         cpu_clock_true_o,
  output reg         cpu_clock_comp_o,
  output reg         chipset_cpu_clock_o,
  output reg         cpu_oe_o,
  output reg  [3:0]  pci_clock_group_o,
  output reg         pci_group_oe_o,
  output reg  [12:0] sdram_clock_o,
  output reg         sdram_oe_o,
  output reg  [3:0]  freq_code_o,
  output reg  [10:0] cpu_freq_tenths_o,
  output reg  [8:0]  pci_freq_tenths_o,
  output reg         halt_mode_o,
  output reg         strap_done_o
);

  // ==========================================
  // Rate tables, tenths of a MHz
  function [10:0] cpu_rate;
    input [3:0] c;
    begin
      case (c)
        4'hF: cpu_rate = 11'd950;
        4'hE: cpu_rate = 11'd1030;
        4'hD: cpu_rate = 11'd1050;
        4'hC: cpu_rate = 11'd1080;
        4'hB: cpu_rate = 11'd900;
        4'hA: cpu_rate = 11'd1100;
        4'h9: cpu_rate = 11'd1150;
        4'h8: cpu_rate = 11'd1200;
        4'h7: cpu_rate = 11'd1333;
        4'h6: cpu_rate = 11'd830;
        4'h5: cpu_rate = 11'd1002;
        4'h4: cpu_rate = 11'd668;
        4'h3: cpu_rate = 11'd1240;
        4'h2: cpu_rate = 11'd1290;
        4'h1: cpu_rate = 11'd1380;
        default: cpu_rate = 11'd1430;
      endcase
    end
  endfunction

  function [8:0] pci_rate;
    input [3:0] c;
    begin
      case (c)
        4'hF: pci_rate = 9'd317;
        4'hE: pci_rate = 9'd343;
        4'hD: pci_rate = 9'd350;
        4'hC: pci_rate = 9'd360;
        4'hB: pci_rate = 9'd300;
        4'hA: pci_rate = 9'd367;
        4'h9: pci_rate = 9'd383;
        4'h8: pci_rate = 9'd300;
        4'h7: pci_rate = 9'd333;
        4'h6: pci_rate = 9'd333;
        4'h5: pci_rate = 9'd333;
        4'h4: pci_rate = 9'd334;
        4'h3: pci_rate = 9'd310;
        4'h2: pci_rate = 9'd323;
        4'h1: pci_rate = 9'd345;
        default: pci_rate = 9'd358;
      endcase
    end
  endfunction

  // ==========================================
  // Input synchronisers
  wire [14:0] raw;
  reg  [14:0] s1_q;
  reg  [14:0] s2_q;
  assign raw = {ref_clock_strong_i, usb48_clock_i, low_rate_fixed_clock_i,
                ref_clock_second_i, pci_clock_one_i, pci_clock_first_i,
                serial_data_line_i, serial_clock_line_i, power_down_n_i,
                buffer_in_i, c24_src_i, usb_src_i, ref_src_i, pci_src_i,
                cpu_src_i};

  // Two flops on every outside input except tristate_i and resetn_i
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      s1_q <= 15'h0000;
      s2_q <= 15'h0000;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  wire cpu_s = s2_q[0];
  wire pd_n  = s2_q[6];
  wire scl   = s2_q[7];
  wire sda   = s2_q[8];

  // ==========================================
  // Strap capture
  reg [15:0] st_cnt_q;
  reg [3:0]  fs_q;
  reg        mode_q;
  reg        done_q;

  // Strap code as the pins show it now, bit 3 first
  wire [3:0] pin_code = {s2_q[12], s2_q[13], s2_q[10], s2_q[11]};

  // Pins undriven until straps are caught, then held
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      st_cnt_q <= 16'h0000;
      fs_q     <= 4'h0;
      mode_q   <= 1'b0;
      done_q   <= 1'b0;
    end
    else if (!done_q)
    begin
      st_cnt_q <= st_cnt_q + 16'h0001;
      if (st_cnt_q == `PCG_STRAP_CYC - 1)
      begin
        fs_q   <= pin_code;
        mode_q <= s2_q[9];
        done_q <= 1'b1;
      end
    end
  end

  // ==========================================
  // Serial slave and control registers
  localparam SI_IDLE = 3'd0;
  localparam SI_ADDR = 3'd1;
  localparam SI_CMD  = 3'd2;
  localparam SI_CNT  = 3'd3;
  localparam SI_WR   = 3'd4;
  localparam SI_RD   = 3'd5;

  reg [7:0] regs_q [0:3];
  reg [2:0] si_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] rd_q;
  reg [2:0] idx_q;
  reg       scl_q;
  reg       sda_q;
  wire      scl_rise = scl & ~scl_q;
  wire      scl_fall = ~scl & scl_q;
  wire [7:0] rd_byte = idx_q[2] ? 8'h00 : regs_q[idx_q[1:0]];

  // Start, stop, byte shifting and acknowledge
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      regs_q[0] <= `PCG_REG0_RST;
      regs_q[1] <= `PCG_REG1_RST;
      regs_q[2] <= `PCG_REG2_RST;
      regs_q[3] <= `PCG_REG3_RST;
      si_q <= SI_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 8'h00;
      idx_q <= 3'd0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      serial_data_line_o <= 1'b0;
      serial_data_line_oe_o <= 1'b0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      serial_data_line_o <= 1'b0;
      if (scl && scl_q && sda_q && !sda)
      begin
        si_q <= SI_ADDR;
        bit_q <= 4'hF; // Start's own clock fall brings the count to zero
        serial_data_line_oe_o <= 1'b0;
      end
      else if (scl && scl_q && !sda_q && sda)
      begin
        si_q <= SI_IDLE;
        serial_data_line_oe_o <= 1'b0;
      end
      else if (si_q != SI_IDLE && scl_rise)
      begin
        if (bit_q != 4'h8)
          sh_q <= {sh_q[6:0], sda};
        else if (si_q == SI_RD && sda)
          si_q <= SI_IDLE; // Master declined more data
      end
      else if (si_q != SI_IDLE && scl_fall)
      begin
        if (bit_q < 4'h7)
        begin
          bit_q <= bit_q + 4'h1;
          if (si_q == SI_RD)
          begin
            rd_q <= {rd_q[6:0], 1'b0};
            serial_data_line_oe_o <= ~rd_q[6];
          end
        end
        else if (bit_q == 4'h7)
        begin
          bit_q <= 4'h8;
          serial_data_line_oe_o <= (si_q != SI_RD);
          case (si_q)
            SI_ADDR:
            begin
              if (sh_q[7:1] != `PCG_DEV_ADDR)
              begin
                si_q <= SI_IDLE;
                serial_data_line_oe_o <= 1'b0;
              end
              else
              begin
                si_q <= sh_q[0] ? SI_RD : SI_CMD;
                idx_q <= 3'd0;
              end
            end
            SI_CMD: si_q <= SI_CNT;
            SI_CNT:
            begin
              si_q <= SI_WR;
              idx_q <= 3'd0;
            end
            SI_WR:
            begin
              if (!idx_q[2])
                regs_q[idx_q[1:0]] <= sh_q;
              if (!idx_q[2])
                idx_q <= idx_q + 3'd1;
            end
            default: si_q <= si_q;
          endcase
        end
        else
        begin
          bit_q <= 4'h0;
          serial_data_line_oe_o <= 1'b0;
          if (si_q == SI_RD)
          begin
            rd_q <= rd_byte;
            serial_data_line_oe_o <= ~rd_byte[7];
            if (!idx_q[2])
              idx_q <= idx_q + 3'd1;
          end
        end
      end
    end
  end

  // ==========================================
  // Frequency selection and smooth ramp
  wire [7:0]  r0 = regs_q[0];
  wire [3:0]  code = r0[`PCG_SWSEL_BIT] ?
                     {r0[`PCG_SOFT_FREQ_BIT3_BIT], r0[6:4]} : fs_q;
  wire [10:0] cpu_tgt = cpu_rate(code);
  reg  [15:0] ramp_q;

  // Step one tenth of a MHz per ramp tick
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      ramp_q <= 16'h0000;
      freq_code_o <= 4'h0;
      cpu_freq_tenths_o <= 11'd0;
      pci_freq_tenths_o <= 9'd0;
    end
    else if (!done_q)
      cpu_freq_tenths_o <= cpu_rate(pin_code);
    else
    begin
      freq_code_o <= code;
      pci_freq_tenths_o <= pci_rate(code);
      ramp_q <= (ramp_q == `PCG_RAMP_CYC - 1) ? 16'h0000 : ramp_q + 16'h0001;
      if (ramp_q == 16'h0000)
      begin
        if (cpu_freq_tenths_o < cpu_tgt)
          cpu_freq_tenths_o <= cpu_freq_tenths_o + 11'd1;
        else if (cpu_freq_tenths_o > cpu_tgt)
          cpu_freq_tenths_o <= cpu_freq_tenths_o - 11'd1;
      end
    end
  end

  // ==========================================
  // Output gating
  reg         halt_q;
  reg  [25:0] run_q;
  wire [7:0]  r1 = regs_q[1];
  wire [7:0]  r2 = regs_q[2];
  wire [7:0]  r3 = regs_q[3];
  wire        on = done_q & pd_n;
  wire        low_src = r3[`PCG_SEL2448_BIT] ? s2_q[3] : s2_q[4];
  wire [25:0] src = {{13{s2_q[5]}}, low_src, s2_q[3], {2{s2_q[2]}},
                     {5{s2_q[1]}}, s2_q[1], cpu_s, ~cpu_s, cpu_s};
  wire [25:0] en;
  assign en[0]     = on & r1[`PCG_CPUEN_BIT] & ~halt_q;
  assign en[1]     = en[0];
  assign en[2]     = on & r1[`PCG_CSEN_BIT] & ~halt_q;
  assign en[3]     = on & r2[`PCG_PCI0EN_BIT];
  assign en[8:4]   = {5{on}} & r2[4:0];
  assign en[9]     = on & mode_q;
  assign en[10]    = on;
  assign en[11]    = on & r3[`PCG_USBEN_BIT];
  assign en[12]    = on & r3[`PCG_LOWEN_BIT];
  assign en[24:13] = {12{on}};
  assign en[25]    = on & r1[`PCG_SD12EN_BIT];

  // Enables move only while each source is low
  always @(posedge clk_i)
  begin : gate
    integer i;
    if (!resetn_i)
    begin
      halt_q <= 1'b0;
      run_q  <= 26'h000_0000;
    end
    else
    begin
      if (!cpu_s)
        halt_q <= ~mode_q & done_q & ~s2_q[14];
      for (i = 0; i < 26; i = i + 1)
        if (!src[i])
          run_q[i] <= en[i];
    end
  end

  // Registered pins and enables
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      {cpu_clock_true_o, cpu_clock_comp_o, chipset_cpu_clock_o} <= 3'h0;
      {pci_clock_first_o, pci_clock_one_o} <= 2'h0;
      pci_clock_group_o <= 4'h0;
      {ref_clock_strong_o, ref_clock_second_o} <= 2'h0;
      {usb48_clock_o, low_rate_fixed_clock_o} <= 2'h0;
      sdram_clock_o <= 13'h0000;
      {cpu_oe_o, pci_group_oe_o, sdram_oe_o} <= 3'h0;
      {pci_clock_first_oe_o, pci_clock_one_oe_o} <= 2'h0;
      {ref_clock_strong_oe_o, ref_clock_second_oe_o} <= 2'h0;
      {usb48_clock_oe_o, low_rate_fixed_clock_oe_o} <= 2'h0;
      halt_mode_o <= 1'b0;
      strap_done_o <= 1'b0;
    end
    else
    begin
      cpu_clock_true_o <= src[0] & run_q[0];
      cpu_clock_comp_o <= src[1] & run_q[1];
      chipset_cpu_clock_o <= src[2] & run_q[2];
      pci_clock_first_o <= src[3] & run_q[3];
      pci_clock_one_o <= src[4] & run_q[4];
      pci_clock_group_o <= src[8:5] & run_q[8:5];
      ref_clock_strong_o <= src[9] & run_q[9];
      ref_clock_second_o <= src[10] & run_q[10];
      usb48_clock_o <= src[11] & run_q[11];
      low_rate_fixed_clock_o <= src[12] & run_q[12];
      sdram_clock_o <= src[25:13] & run_q[25:13];
      cpu_oe_o <= ~tristate_i[0];
      pci_group_oe_o <= ~tristate_i[1];
      sdram_oe_o <= ~tristate_i[2];
      pci_clock_first_oe_o <= done_q & ~tristate_i[1];
      pci_clock_one_oe_o <= done_q & ~tristate_i[1];
      ref_clock_second_oe_o <= done_q & ~tristate_i[3];
      ref_clock_strong_oe_o <= done_q & mode_q & ~tristate_i[3];
      usb48_clock_oe_o <= done_q & ~tristate_i[4];
      low_rate_fixed_clock_oe_o <= done_q & ~tristate_i[4];
      halt_mode_o <= done_q & ~mode_q;
      strap_done_o <= done_q;
    end
  end

endmodule
`default_nettype wire

//--- shared/pcg_defs.vh
// Constants for the clock generator control block
`ifndef PCG_DEFS_VH
`define PCG_DEFS_VH
// Serial slave address, seven bits
`define PCG_DEV_ADDR    7'h69
// Register power-up values
`define PCG_REG0_RST    8'h00
`define PCG_REG1_RST    8'h0B
`define PCG_REG2_RST    8'hFF
`define PCG_REG3_RST    8'h30
// Field positions
`define PCG_SWSEL_BIT   3
`define PCG_SOFT_FREQ_BIT3_BIT   2
`define PCG_CPUEN_BIT   1
`define PCG_CSEN_BIT    0
`define PCG_SD12EN_BIT  3
`define PCG_PCI0EN_BIT  6
`define PCG_SEL2448_BIT 6
`define PCG_USBEN_BIT   5
`define PCG_LOWEN_BIT   4
// Timing
`define PCG_CLK_MHZ     100
`define PCG_STRAP_NS    1000
`define PCG_STRAP_CYC   ((`PCG_STRAP_NS * `PCG_CLK_MHZ + 999) / 1000)
`define PCG_RAMP_NS     500
`define PCG_RAMP_CYC    ((`PCG_RAMP_NS * `PCG_CLK_MHZ) / 1000)
`endif

//--- sim/pcg_ctrl_monitor.sv
// Checker for the clock generator control block
`timescale 1ns/100ps
`default_nettype none
module pcg_ctrl_monitor (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        power_down_n_i,
  input wire logic        buffer_in_i,
  input wire logic        ref_clock_strong_i,
  input wire logic [4:0]  tristate_i,
  input wire logic        cpu_clock_true_o,
  input wire logic        cpu_clock_comp_o,
  input wire logic        chipset_cpu_clock_o,
  input wire logic        cpu_oe_o,
  input wire logic [3:0]  pci_clock_group_o,
  input wire logic        pci_clock_first_o,
  input wire logic [12:0] sdram_clock_o,
  input wire logic        sdram_oe_o,
  input wire logic [10:0] cpu_freq_tenths_o,
  input wire logic        halt_mode_o,
  input wire logic        strap_done_o
);
  // ==========================================
  // Settle counters
  logic [4:0] hi_q;
  logic [4:0] lo_q;
  logic [4:0] hl_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Cycles since power-down, strap latch or halt pin last moved, saturating
  always @(posedge clk_i)
  begin
    hi_q <= (!resetn_i || !power_down_n_i || !strap_done_o) ? 5'h00 : hi_q + {4'h0, ~&hi_q};
    lo_q <= (!resetn_i || power_down_n_i) ? 5'h00 : lo_q + {4'h0, ~&lo_q};
    hl_q <= (!resetn_i || ref_clock_strong_i) ? 5'h00 : hl_q + {4'h0, ~&hl_q};
  end

  // ==========================================
  // Properties
  AST_PD_STOP: assert property (lo_q >= 5'h10 |-> !cpu_clock_true_o && !pci_clock_first_o &&
    pci_clock_group_o == 4'h0 && sdram_clock_o == 13'h0000) else $error("output runs in power-down");
  AST_SD_FAN: assert property (hi_q >= 5'h10 && strap_done_o |->
    sdram_clock_o[11:0] == {12{$past(buffer_in_i, 3)}}) else $error("memory clock not following buffer");
  AST_HALT: assert property (halt_mode_o && hl_q >= 5'h0C |->
    !cpu_clock_true_o && !chipset_cpu_clock_o) else $error("cpu clock runs while halted");
  AST_PAIR: assert property (chipset_cpu_clock_o |-> cpu_clock_true_o && !cpu_clock_comp_o)
    else $error("chipset clock out of phase");
  AST_HOLD: assert property (strap_done_o && $past(strap_done_o) |-> $stable(halt_mode_o))
    else $error("latched mode changed");
  AST_LATCH: assert property ($rose(strap_done_o) |-> $past(resetn_i, 100))
    else $error("straps latched too early");
  AST_RAMP: assert property ($changed(cpu_freq_tenths_o) && $past(strap_done_o) |->
    (cpu_freq_tenths_o - $past(cpu_freq_tenths_o) == 11'h001 || $past(cpu_freq_tenths_o) - cpu_freq_tenths_o == 11'h001)
    ##1 $stable(cpu_freq_tenths_o)[*8]) else $error("cpu rate jumped");
  AST_OE: assert property ($past(resetn_i) |-> cpu_oe_o == !$past(tristate_i[0]) &&
    sdram_oe_o == !$past(tristate_i[2])) else $error("drive enable wrong");
endmodule
bind pcg_ctrl pcg_ctrl_monitor u_mon (.clk_i, .resetn_i, .power_down_n_i, .buffer_in_i, .ref_clock_strong_i,
  .tristate_i, .cpu_clock_true_o, .cpu_clock_comp_o, .chipset_cpu_clock_o, .cpu_oe_o, .pci_clock_group_o,
  .pci_clock_first_o, .sdram_clock_o, .sdram_oe_o, .cpu_freq_tenths_o, .halt_mode_o, .strap_done_o);
`default_nettype wire

//--- sim/pcg_serial_host.sv
// Two-wire bus controller model for the serial port
`timescale 1ns/100ps
`default_nettype none
module pcg_serial_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_o
);
  // ==========================================
  // Bus idles with clock high and data released
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One bit slot: data moves mid-low, sampled mid-high
  task automatic slot(input logic b, output logic s);
    tick(4);
    sda_o <= b;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    s = sda_i;
    tick(4);
    scl_o <= 1'b0;
  endtask

  // Data falls while clock high
  task automatic start();
    tick(8);
    sda_o <= 1'b0;
    tick(8);
    scl_o <= 1'b0;
  endtask

  // Data rises while clock high
  task automatic stop();
    tick(4);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b1;
    tick(8);
    sda_o <= 1'b1;
    tick(8);
  endtask

  // Whole byte, MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] w, input logic l, output logic [7:0] r, output logic n);
    for (int i = 7; i >= 0; i--)
      slot(w[i], r[i]);
    slot(l, n);
  endtask
endmodule
`default_nettype wire

//--- sim/pc_clock_generator_control_test.sv
// Self-checking bench for the clock generator control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin checks++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module pc_clock_generator_control_test;
  // ==========================================
  // Stimulus and observed signals
  logic clk_i = 1'b0, resetn_i = 1'b0, power_down_n_i = 1'b1, buffer_in_i = 1'b0, mode = 1'b1, halt_n = 1'b1;
  logic cpu_src_i = 1'b0, pci_src_i = 1'b0, ref_src_i = 1'b0, usb_src_i = 1'b0, c24_src_i = 1'b0;
  logic [4:0] tristate_i = 5'h00;
  logic [3:0] strap = 4'h0, seen, freq_code_o, pci_clock_group_o;
  logic [7:0] rm [4];
  logic [7:0] rb;
  logic nk, scl, sda_h, serial_data_line_o, serial_data_line_oe_o, pci_clock_first_o, pci_clock_first_oe_o;
  logic pci_clock_one_o, pci_clock_one_oe_o, ref_clock_second_o, ref_clock_second_oe_o, usb48_clock_o;
  logic low_rate_fixed_clock_o, low_rate_fixed_clock_oe_o, usb48_clock_oe_o, ref_clock_strong_o;
  logic ref_clock_strong_oe_o, cpu_clock_true_o, cpu_clock_comp_o, chipset_cpu_clock_o, cpu_oe_o;
  logic pci_group_oe_o, sdram_oe_o, halt_mode_o, strap_done_o;
  logic [12:0] sdram_clock_o;
  logic [10:0] cpu_freq_tenths_o, v;
  logic [8:0] pci_freq_tenths_o;
  int seed = 3649, n_errors = 0, checks = 0, cyc = 0;
  int cpu_t[16] = '{1430, 1380, 1290, 1240, 668, 1002, 830, 1333, 1200, 1150, 1100, 900, 1080, 1050, 1030, 950};
  int pci_t[16] = '{358, 345, 323, 310, 334, 333, 333, 333, 300, 383, 367, 300, 360, 350, 343, 317};
  // Pins read the strap resistors unless driven; data line pulled up
  wire serial_clock_line_i = scl;
  wire serial_data_line_i = sda_h & ~serial_data_line_oe_o;
  wire pci_clock_first_i = pci_clock_first_oe_o ? pci_clock_first_o : mode;
  wire pci_clock_one_i = pci_clock_one_oe_o ? pci_clock_one_o : strap[1];
  wire ref_clock_second_i = ref_clock_second_oe_o ? ref_clock_second_o : strap[0];
  wire usb48_clock_i = usb48_clock_oe_o ? usb48_clock_o : strap[2];
  wire low_rate_fixed_clock_i = low_rate_fixed_clock_oe_o ? low_rate_fixed_clock_o : strap[3];
  wire ref_clock_strong_i = ref_clock_strong_oe_o ? ref_clock_strong_o : halt_n;

  pcg_ctrl u_dut (.clk_i, .resetn_i, .cpu_src_i, .pci_src_i, .ref_src_i, .usb_src_i, .c24_src_i, .buffer_in_i,
    .power_down_n_i, .tristate_i, .serial_clock_line_i, .serial_data_line_i, .serial_data_line_o,
    .serial_data_line_oe_o, .pci_clock_first_i, .pci_clock_first_o, .pci_clock_first_oe_o, .pci_clock_one_i,
    .pci_clock_one_o, .pci_clock_one_oe_o, .ref_clock_second_i, .ref_clock_second_o, .ref_clock_second_oe_o,
    .low_rate_fixed_clock_i, .low_rate_fixed_clock_o, .low_rate_fixed_clock_oe_o, .usb48_clock_i, .usb48_clock_o,
    .usb48_clock_oe_o, .ref_clock_strong_i, .ref_clock_strong_o, .ref_clock_strong_oe_o, .cpu_clock_true_o,
    .cpu_clock_comp_o, .chipset_cpu_clock_o, .cpu_oe_o, .pci_clock_group_o, .pci_group_oe_o, .sdram_clock_o,
    .sdram_oe_o, .freq_code_o, .cpu_freq_tenths_o, .pci_freq_tenths_o, .halt_mode_o, .strap_done_o);
  pcg_serial_host u_host (.clk_i(clk_i), .sda_i(serial_data_line_i), .scl_o(scl), .sda_o(sda_h));

  // Clock, source patterns, random buffer and tri-state, run limit
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    {c24_src_i, usb_src_i, ref_src_i, pci_src_i, cpu_src_i} <= {cyc[5], cyc[2], cyc[4], cyc[2], cyc[1]};
    buffer_in_i <= cyc[2] & 1'($random(seed));
    tristate_i <= 5'($random(seed));
    if (cyc == 40000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  // ==========================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic power_up(input logic [3:0] c, input logic m);
    resetn_i <= 1'b0;
    strap <= c;
    mode <= m;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (50) @(posedge clk_i);
    `CHK("strap pin idle", 1'b0, pci_clock_one_oe_o)
    for (int i = 0; i < 200 && strap_done_o !== 1'b1; i++)
      @(posedge clk_i);
    rm = '{8'h00, 8'h0B, 8'hFF, 8'h30};
  endtask

  // Frame of address, dummy command, dummy count, then n registers from 0
  task automatic wr_regs(input int n, input logic [31:0] d);
    logic [55:0] f;
    f = {d, 8'(n), 8'h00, 8'hD2};
    u_host.start();
    for (int i = 0; i < 3 + n; i++)
    begin
      u_host.xfer(f[8*i +: 8], 1'b1, rb, nk);
      `CHK("write ack", 1'b0, nk)
      if (i > 2)
        rm[i-3] = f[8*i +: 8];
    end
    u_host.stop();
    @(posedge clk_i);
  endtask

  task automatic rd_regs();
    u_host.start();
    u_host.xfer(8'hD3, 1'b1, rb, nk);
    `CHK("read ack", 1'b0, nk)
    for (int i = 0; i < 4; i++)
    begin
      u_host.xfer(8'hFF, i == 3, rb, nk);
      `CHK("read back", rm[i], rb)
    end
    u_host.stop();
  endtask

  // Which outputs toggled: sdram, pci group, pci first, cpu true
  task automatic gate_chk(input logic [3:0] e);
    repeat (16) @(posedge clk_i);
    seen = 4'h0;
    repeat (40)
    begin
      @(posedge clk_i);
      seen |= {|sdram_clock_o, |pci_clock_group_o, pci_clock_first_o, cpu_clock_true_o};
    end
    `CHK("running outputs", e, seen)
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    for (int k = 0; k < 16; k++)
    begin
      power_up(4'(k), k[0]);
      @(posedge clk_i);
      `CHK("code", 4'(k), freq_code_o)
      `CHK("cpu rate", 11'(cpu_t[k]), cpu_freq_tenths_o)
      `CHK("pci rate", 9'(pci_t[k]), pci_freq_tenths_o)
      `CHK("mode", ~k[0], halt_mode_o)
      strap <= ~strap;
      repeat (20) @(posedge clk_i);
      `CHK("held code", 4'(k), freq_code_o)
    end
    $display("strap test done");
    power_up(4'h0, 1'b0);
    halt_n <= 1'b0;
    gate_chk(4'hE);
    halt_n <= 1'b1;
    gate_chk(4'hF);
    power_down_n_i <= 1'b0;
    gate_chk(4'h0);
    power_down_n_i <= 1'b1;
    gate_chk(4'hF);
    $display("gating test done");
    for (int k = 0; k < 16; k++)
    begin
      wr_regs(1, {24'h00_0000, 1'b0, 3'(k), 1'b1, 1'(k >> 3), 2'h0});
      `CHK("soft code", 4'(k), freq_code_o)
      `CHK("soft pci rate", 9'(pci_t[k]), pci_freq_tenths_o)
    end
    wr_regs(1, 32'h0000_0000);
    `CHK("strap code back", 4'h0, freq_code_o)
    v = cpu_freq_tenths_o;
    repeat (120) @(posedge clk_i);
    v = cpu_freq_tenths_o - v;
    `CHK("ramp steps", 1'b1, v == 11'h002 || v == 11'h003)
    $display("select test done");
    wr_regs(4, 32'h70C0_0800);
    gate_chk(4'hA);
    // Fixed clocks: low-rate pin carries 48, second ref runs, strong ref idle in halt mode
    seen = 4'h0;
    repeat (40)
    begin
      @(posedge clk_i);
      seen |= {low_rate_fixed_clock_o != usb48_clock_o, usb48_clock_o, ref_clock_second_o, ref_clock_strong_o};
    end
    `CHK("fixed clocks", 4'h6, seen)
    rd_regs();
    u_host.start();
    u_host.xfer(8'hA4, 1'b1, rb, nk);
    `CHK("foreign address", 1'b1, nk)
    u_host.stop();
    $display("serial test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
